// >>> hdl/compass_link_pkg.sv
// Purpose: shared constants for the two-wire sensor port and its bus master
// Assumes: fast-mode bus rate, 200 MHz master clock
// Notes: register group bounds drive the address counter wrap
package compass_link_pkg;
  // fixed upper bits of the slave address
  localparam logic [4:0] SLAVE_ADDR_HI = 5'h07;
  // register group bounds
  localparam logic [7:0] RESULT_FIRST = 8'hc0;
  localparam logic [7:0] RESULT_DATA_FIRST = 8'hc1;
  localparam logic [7:0] RESULT_LAST = 8'hc4;
  localparam logic [7:0] SETUP_FIRST = 8'he0;
  localparam logic [7:0] SETUP_LAST = 8'he6;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // bus rates the port must follow, and the one the master produces
  localparam int STD_RATE_KHZ = 100;
  localparam int FAST_RATE_KHZ = 400;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCL_PERIOD_NS = 1000000 / FAST_RATE_KHZ;
  localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] QUARTER_LOAD = 8'(QUARTER_CYC - 1);
  // master command codes
  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ = 2'h2,
    CMD_STOP = 2'h3
  } cmd_t;
endpackage

// >>> hdl/compass_link_if.sv
// Purpose: two-wire bus between the master and the sensor port
// Assumes: open-drain wires with pull-ups
// Notes: a line is low whenever any enabled driver drives low
`timescale 1ns/1ps
`default_nettype none
interface compass_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // wired-and resolution of both lines
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
    output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

// >>> hdl/pin_filter.sv
// Purpose: two-flop synchroniser with a one-sample glitch filter per bit
// Assumes: idle level of the pins is high
// Notes: output moves only after two equal synchronised samples
`timescale 1ns/1ps
`default_nettype none
module pin_filter #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] hold_r;
  logic [WIDTH-1:0] dout_r;
  genvar i;
  // per bit: meta feeds sync only, the filter looks at sync and hold
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          meta_r[i] <= 1'b1;
          sync_r[i] <= 1'b1;
          hold_r[i] <= 1'b1;
          dout_r[i] <= 1'b1;
        end
        else
        begin
          meta_r[i] <= din[i];
          sync_r[i] <= meta_r[i];
          hold_r[i] <= sync_r[i];
          if (sync_r[i] == hold_r[i])
            dout_r[i] <= hold_r[i];
        end
      end
    end
  endgenerate
  assign dout = dout_r;
endmodule // pin_filter
`default_nettype wire

// >>> hdl/compass_i2c_slave_port.sv
// Purpose: two-wire slave port giving a bus master access to 8-bit registers
// Assumes: runs on the link clock, register file answers rd_data the same cycle
// Notes: sda is open drain, oe high pulls the line low
// How it works
// - works at 100 kHz and 400 kHz bus rates
// - data changes only while scl is low
// - sda falling with scl high is a start
// - sda rising with scl high is a stop
// - receiver pulls sda low in ack slot
// - acknowledge only a matching slave address
// - seven-bit address, upper five fixed 00111
// - two low address bits from select pins
// - first byte lsb one reads, zero writes
// - second write byte loads address counter
// - later write bytes are acked and stored
// - each further byte goes to next address
// - writes wrap from e6 back to e0
// - after sending, release and sample master ack
// - master nack stops sending until stop or repeated start
// - reads wrap c4 to c0, e6 to e0
// - counter holds address after last access
// - current read sends counter byte then increments
// - master sets address before repeated start read
// - random read sends supplied address then increments
// - finished result read signals interrupt clear
// - master writes only mode register while measuring; the port stores every write at any time
`timescale 1ns/1ps
`default_nettype none
module compass_i2c_slave_port
  import compass_link_pkg::*;
(
  input wire logic link_clk,
  input wire logic rst,
  compass_link_if.dev bus,
  input wire logic [1:0] slave_address_select_pins,
  output logic [7:0] rd_addr,
  output logic rd_stb,
  input wire logic [7:0] rd_data,
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic result_read
);
  typedef enum logic [5:0] {
    D_IDLE = 6'h01,
    D_ADDR = 6'h02,
    D_REGA = 6'h04,
    D_WDATA = 6'h08,
    D_RDATA = 6'h10,
    D_WAIT = 6'h20
  } dstate_t;

  dstate_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic ack_r, ack_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic oe_r, oe_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic [7:0] ra_r, ra_nxt;
  logic dir_r, dir_nxt;
  logic mack_r, mack_nxt;
  logic wr_r, wr_nxt;
  logic [7:0] wa_r, wa_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic res_r, res_nxt;
  logic scl_q, sda_q;
  logic [1:0] lines_s;
  logic [1:0] sel_s;
  logic scl_s, sda_s;

  // next counter value with wrap inside each register group
  function automatic logic [7:0] next_addr(input logic [7:0] a);
    if (a == RESULT_LAST)
      return RESULT_FIRST;
    else if (a == SETUP_LAST)
      return SETUP_FIRST;
    else
      return a + 8'h01;
  endfunction

  // bus lines and address straps, synchronised and deglitched
  pin_filter #(.WIDTH(2)) u_lines (
    .clk(link_clk),
    .rst(rst),
    .din({bus.scl, bus.sda}),
    .dout(lines_s)
  );
  pin_filter #(.WIDTH(2)) u_sel (
    .clk(link_clk),
    .rst(rst),
    .din(slave_address_select_pins),
    .dout(sel_s)
  );
  assign scl_s = lines_s[1];
  assign sda_s = lines_s[0];

  // edge and condition decode on filtered samples, fast enough for both rates
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_seen = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_seen = scl_s & scl_q & ~sda_q & sda_s;
  wire receiving = (st_r == D_ADDR) | (st_r == D_REGA) | (st_r == D_WDATA);
  wire sending = (st_r == D_RDATA);
  wire bit_in = receiving & scl_rise & (cnt_r < BITS_PER_BYTE);
  wire byte_in = receiving & scl_fall & (cnt_r == BITS_PER_BYTE) & ~ack_r;
  wire ack_end = scl_fall & ack_r;
  wire addr_hit = (sh_r[7:1] == {SLAVE_ADDR_HI, sel_s});
  wire tx_shift = sending & scl_fall & (cnt_r < BITS_PER_BYTE);
  wire mack_slot = sending & scl_rise & (cnt_r == BITS_PER_BYTE);
  wire tx_done = sending & scl_fall & (cnt_r == BITS_PER_BYTE);
  wire first_load = ack_end & (st_r == D_ADDR) & dir_r;
  wire next_load = tx_done & mack_r;
  wire load = ~start_seen & ~stop_seen & (first_load | next_load);
  wire ra_result = (ra_r >= RESULT_DATA_FIRST) & (ra_r <= RESULT_LAST);

  // byte engine: receive, acknowledge, transmit
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    ack_nxt = ack_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    oe_nxt = oe_r;
    ptr_nxt = ptr_r;
    ra_nxt = ra_r;
    dir_nxt = dir_r;
    mack_nxt = mack_r;
    wr_nxt = 1'b0;
    wa_nxt = wa_r;
    wd_nxt = wd_r;
    res_nxt = 1'b0;
    if (stop_seen)
    begin
      st_nxt = D_IDLE;
      ack_nxt = 1'b0;
      oe_nxt = 1'b0;
    end
    else if (start_seen)
    begin
      st_nxt = D_ADDR;
      cnt_nxt = 4'h0;
      ack_nxt = 1'b0;
      oe_nxt = 1'b0;
    end
    else if (bit_in)
    begin
      sh_nxt = {sh_r[6:0], sda_s};
      cnt_nxt = cnt_r + 4'h1;
    end
    else if (byte_in)
    begin
      ack_nxt = 1'b1;
      oe_nxt = 1'b1;
      if (st_r == D_ADDR)
      begin
        dir_nxt = sh_r[0];
        if (!addr_hit)
        begin
          st_nxt = D_WAIT;
          ack_nxt = 1'b0;
          oe_nxt = 1'b0;
        end
      end
      else if (st_r == D_REGA)
        ptr_nxt = sh_r;
      else
      begin
        wr_nxt = 1'b1;
        wa_nxt = ptr_r;
        wd_nxt = sh_r;
        ptr_nxt = next_addr(ptr_r);
      end
    end
    else if (ack_end)
    begin
      ack_nxt = 1'b0;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
      if (st_r == D_ADDR)
        st_nxt = dir_r ? D_RDATA : D_REGA;
      else if (st_r == D_REGA)
        st_nxt = D_WDATA;
    end
    else if (mack_slot)
      mack_nxt = ~sda_s;
    else if (tx_shift)
    begin
      cnt_nxt = cnt_r + 4'h1;
      tx_nxt = {tx_r[6:0], 1'b1};
      oe_nxt = (cnt_r == 4'h7) ? 1'b0 : ~tx_r[6];
    end
    else if (tx_done)
    begin
      res_nxt = ra_result;
      if (!mack_r)
      begin
        st_nxt = D_WAIT;
        oe_nxt = 1'b0;
      end
    end
    if (load)
    begin
      tx_nxt = rd_data;
      oe_nxt = ~rd_data[7];
      ra_nxt = ptr_r;
      ptr_nxt = next_addr(ptr_r);
      cnt_nxt = 4'h0;
    end
  end

  // state registers
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= D_IDLE;
      cnt_r <= 4'h0;
      ack_r <= 1'b0;
      sh_r <= 8'h00;
      tx_r <= 8'hff;
      oe_r <= 1'b0;
      ptr_r <= ADDR_RESET;
      ra_r <= ADDR_RESET;
      dir_r <= 1'b0;
      mack_r <= 1'b0;
      wr_r <= 1'b0;
      wa_r <= ADDR_RESET;
      wd_r <= 8'h00;
      res_r <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      ack_r <= ack_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      oe_r <= oe_nxt;
      ptr_r <= ptr_nxt;
      ra_r <= ra_nxt;
      dir_r <= dir_nxt;
      mack_r <= mack_nxt;
      wr_r <= wr_nxt;
      wa_r <= wa_nxt;
      wd_r <= wd_nxt;
      res_r <= res_nxt;
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // outputs
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = oe_r;
  assign rd_addr = ptr_r;
  assign rd_stb = load;
  assign wr_stb = wr_r;
  assign wr_addr = wa_r;
  assign wr_data = wd_r;
  assign result_read = res_r;
endmodule // compass_i2c_slave_port
`default_nettype wire

// >>> hdl/twowire_master.sv
// Purpose: byte-level two-wire bus master driving scl from a divider
// Assumes: 200 MHz clk, one command at a time, stop only after a start
// Notes: scl and sda are open drain, oe high pulls low; no clock stretching
`timescale 1ns/1ps
`default_nettype none
module twowire_master
  import compass_link_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  compass_link_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire cmd_t cmd_kind,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_ack,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);
  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_START = 4'h2,
    H_BIT = 4'h4,
    H_STOP = 4'h8
  } hstate_t;

  hstate_t st_r, st_nxt;
  logic [7:0] tick_r, tick_nxt;
  logic [1:0] q_r, q_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [8:0] sh_r, sh_nxt;
  logic [8:0] rx_r, rx_nxt;
  logic scl_oe_r, scl_oe_nxt;
  logic sda_oe_r, sda_oe_nxt;
  logic rv_r, rv_nxt;
  logic [0:0] sda_s;

  // sda comes back from the wire, so it is synchronised first
  pin_filter #(.WIDTH(1)) u_sda (
    .clk(clk),
    .rst(rst),
    .din(bus.sda),
    .dout(sda_s)
  );

  wire tick_done = (tick_r == 8'h00);
  wire step = (st_r != H_IDLE) & tick_done;
  wire last_q = (q_r == 2'h3);
  assign cmd_ready = (st_r == H_IDLE);

  // quarter-period sequencer: start, nine-bit byte slot, stop
  always_comb
  begin
    st_nxt = st_r;
    tick_nxt = tick_r;
    q_nxt = q_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    rx_nxt = rx_r;
    scl_oe_nxt = scl_oe_r;
    sda_oe_nxt = sda_oe_r;
    rv_nxt = 1'b0;
    if (st_r == H_IDLE)
    begin
      tick_nxt = QUARTER_LOAD;
      q_nxt = 2'h0;
      bit_nxt = 4'h0;
      if (cmd_valid)
      begin
        unique case (cmd_kind)
          CMD_START: st_nxt = H_START;
          CMD_STOP: st_nxt = H_STOP;
          CMD_WRITE:
          begin
            st_nxt = H_BIT;
            sh_nxt = {cmd_data, 1'b1};
          end
          CMD_READ:
          begin
            st_nxt = H_BIT;
            sh_nxt = {8'hff, ~cmd_ack};
          end
        endcase
      end
    end
    else if (!tick_done)
      tick_nxt = tick_r - 8'h01;
    else
    begin
      tick_nxt = QUARTER_LOAD;
      q_nxt = q_r + 2'h1;
    end
    if (step)
    begin
      unique case (q_r)
        2'h0: sda_oe_nxt = (st_r == H_BIT) ? ~sh_r[8] : (st_r == H_STOP);
        2'h1: scl_oe_nxt = 1'b0;
        2'h2:
        begin
          if (st_r == H_BIT)
            rx_nxt = {rx_r[7:0], sda_s[0]};
          sda_oe_nxt = (st_r == H_START) ? 1'b1 : (st_r == H_BIT) ? sda_oe_r : 1'b0;
        end
        2'h3:
        begin
          scl_oe_nxt = (st_r != H_STOP);
          sh_nxt = {sh_r[7:0], 1'b1};
          bit_nxt = bit_r + 4'h1;
        end
      endcase
    end
    if (step && last_q && ((st_r != H_BIT) || (bit_r == BITS_PER_BYTE)))
    begin
      st_nxt = H_IDLE;
      rv_nxt = 1'b1;
    end
  end

  // state registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= H_IDLE;
      tick_r <= 8'h00;
      q_r <= 2'h0;
      bit_r <= 4'h0;
      sh_r <= 9'h1ff;
      rx_r <= 9'h000;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      rv_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      tick_r <= tick_nxt;
      q_r <= q_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      rx_r <= rx_nxt;
      scl_oe_r <= scl_oe_nxt;
      sda_oe_r <= sda_oe_nxt;
      rv_r <= rv_nxt;
    end
  end

  // outputs; ack slot sample is rx bit 0
  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = scl_oe_r;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = sda_oe_r;
  assign rsp_valid = rv_r;
  assign rsp_data = rx_r[8:1];
  assign rsp_nack = rx_r[0];
endmodule // twowire_master
`default_nettype wire

// >>> dv/compass_i2c_slave_port_props.sv
// Purpose: wire checks on the link between master and sensor port
// Assumes: lines watched at the master clock rate
// Notes: addr_sel follows the strap pins that the bench drives
`timescale 1ns/1ps
`default_nettype none
module compass_i2c_slave_port_props
  import compass_link_pkg::*;
(
  input wire logic clk,
  input wire logic [1:0] addr_sel,
  input wire logic link_clk,
  input wire logic rst,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_r, sda_r, first_r, hit_r, rw_r, nack_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  // line events and the ack slot of each byte
  wire start_w = scl_r & scl & sda_r & ~sda;
  wire rise_w = scl & ~scl_r;
  wire fall_w = ~scl & scl_r;
  wire ack_w = rise_w & (cnt_r == 4'h8);
  wire match_w = sh_r[7:1] == {SLAVE_ADDR_HI, addr_sel};
  wire rd_ack_w = ack_w & ~first_r & hit_r & rw_r;
  wire due_w = first_r ? match_w : (hit_r & ~rw_r);
  // bit tracker restarted by each start
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {scl_r, sda_r, first_r, hit_r, rw_r, nack_r} <= 6'h30;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
    end
    else
    begin
      scl_r <= scl;
      sda_r <= sda;
      if (start_w)
      begin
        cnt_r <= 4'h0;
        first_r <= 1'b1;
        nack_r <= 1'b0;
      end
      else if (ack_w)
      begin
        cnt_r <= 4'h0;
        first_r <= 1'b0;
        hit_r <= first_r ? match_w : hit_r;
        rw_r <= first_r ? sh_r[0] : rw_r;
        nack_r <= nack_r | (rd_ack_w & sda);
      end
      else if (rise_w)
      begin
        cnt_r <= cnt_r + 4'h1;
        sh_r <= {sh_r[6:0], sda};
      end
    end
  end
  a_dev_open_drain: assert property (@(posedge link_clk) disable iff (rst)
    dev_sda_oe |-> !dev_sda_o) else $error("device drives sda high");
  a_dev_scl_low: assert property (@(posedge link_clk) disable iff (rst)
    $changed(dev_sda_oe) |-> !scl) else $error("device sda moved with scl high");
  a_addr_ack: assert property (@(posedge clk) disable iff (rst)
    ack_w && first_r |-> sda == !match_w) else $error("address ack wrong");
  a_write_ack: assert property (@(posedge clk) disable iff (rst)
    ack_w && !first_r && hit_r && !rw_r |-> !sda) else $error("write byte not acked");
  a_ack_timely: assert property (@(posedge clk) disable iff (rst)
    fall_w && cnt_r == 4'h8 && due_w |-> ##[1:60] dev_sda_oe) else $error("ack late");
  a_read_release: assert property (@(posedge clk) disable iff (rst)
    rd_ack_w |-> !dev_sda_oe) else $error("sda held in master ack slot");
  a_nack_silent: assert property (@(posedge clk) disable iff (rst)
    nack_r |-> !dev_sda_oe) else $error("device drives after nack");
  a_miss_silent: assert property (@(posedge clk) disable iff (rst)
    !first_r && !hit_r |-> !dev_sda_oe) else $error("device drives when not addressed");
  a_host_open_drain: assert property (@(posedge clk) disable iff (rst)
    !(host_scl_oe && host_scl_o) && !(host_sda_oe && host_sda_o))
    else $error("master drives a line high");
endmodule // compass_i2c_slave_port_props
`default_nettype wire

// >>> dv/compass_i2c_slave_port_tb.sv
// Purpose: bench joining master and sensor port over one link
// Assumes: register file modelled here, rd_data answered at once
// Notes: every master command goes through op
`timescale 1ns/1ps
`default_nettype none
module compass_i2c_slave_port_tb;
  import compass_link_pkg::*;
  localparam logic [1:0] SEL = 2'h2;
  localparam logic [7:0] A_WR = {SLAVE_ADDR_HI, SEL, 1'b0};
  localparam logic [7:0] A_RD = {SLAVE_ADDR_HI, SEL, 1'b1};
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  cmd_t cmd_kind = CMD_START;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ack = 1'b0;
  logic [1:0] sel_pins = SEL;
  logic cmd_ready, rsp_valid, rsp_nack, rd_stb, wr_stb, result_read;
  logic [7:0] rsp_data, rd_addr, wr_addr, wr_data, rd_data;
  logic [7:0] regs [256];
  int fails = 0;
  int n_compared = 0;
  int n_res = 0;
  int n_rd = 0;
  compass_link_if compass_link_if_i ();
  // clocks of 5 ns and 32 ns, rising edges never aligned
  always #2.5 clk = ~clk;
  always #16 link_clk = ~link_clk;
  // register file and result read counter
  assign rd_data = regs[rd_addr];
  always @(posedge link_clk)
  begin
    if (wr_stb)
      regs[wr_addr] <= wr_data;
    if (result_read)
      n_res <= n_res + 1;
    if (rd_stb)
      n_rd <= n_rd + 1;
  end
  twowire_master twowire_master_i (.clk(clk), .rst(rst), .bus(compass_link_if_i),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_data(cmd_data),
    .cmd_ack(cmd_ack), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  compass_i2c_slave_port compass_i2c_slave_port_i (.link_clk(link_clk), .rst(rst),
    .bus(compass_link_if_i), .slave_address_select_pins(sel_pins), .rd_addr(rd_addr),
    .rd_stb(rd_stb), .rd_data(rd_data), .wr_stb(wr_stb), .wr_addr(wr_addr),
    .wr_data(wr_data), .result_read(result_read));
  compass_i2c_slave_port_props compass_i2c_slave_port_props_i (
    .clk(clk), .addr_sel(sel_pins), .link_clk(link_clk), .rst(rst),
    .host_scl_o(compass_link_if_i.host_scl_o), .host_scl_oe(compass_link_if_i.host_scl_oe),
    .host_sda_o(compass_link_if_i.host_sda_o), .host_sda_oe(compass_link_if_i.host_sda_oe),
    .dev_sda_o(compass_link_if_i.dev_sda_o), .dev_sda_oe(compass_link_if_i.dev_sda_oe),
    .scl(compass_link_if_i.scl), .sda(compass_link_if_i.sda));
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // one master command, bounded waits for take and completion
  task automatic op(input cmd_t k, input logic [7:0] d, input logic a);
    int n;
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_data <= d;
    cmd_ack <= a;
    for (n = 0; n < 100 && cmd_ready !== 1'b1; n++)
      @(posedge clk);
    if (n == 100)
    begin
      fails++;
      $display("BAD ready expected 1 seen 0");
      print_verdict();
    end
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (n = 0; n < 6000 && rsp_valid !== 1'b1; n++)
      @(posedge clk);
    if (n == 6000)
    begin
      fails++;
      $display("BAD completion expected 1 seen 0");
      print_verdict();
    end
  endtask
  task automatic wb(input logic [7:0] d, input logic nack);
    op(CMD_WRITE, d, 1'b0);
    check8("ack slot", {7'h00, nack}, {7'h00, rsp_nack});
  endtask
  task automatic rb(input logic ack, input logic [7:0] exp);
    op(CMD_READ, 8'h00, ack);
    check8("read data", exp, rsp_data);
  endtask
  // main sequence
  initial
  begin
    for (int i = 0; i < 256; i++)
      regs[i] = 8'(i) ^ 8'h5a;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    op(CMD_START, 8'h00, 1'b0);
    wb(A_WR, 1'b0);
    wb(8'he5, 1'b0);
    wb(8'h11, 1'b0);
    wb(8'h22, 1'b0);
    wb(8'h33, 1'b0);
    op(CMD_STOP, 8'h00, 1'b0);
    check8("reg e5", 8'h11, regs[8'he5]);
    check8("reg e6", 8'h22, regs[8'he6]);
    check8("reg e0", 8'h33, regs[8'he0]);
    check8("counter", 8'he1, rd_addr);
    $display("test write_burst done");
    op(CMD_START, 8'h00, 1'b0);
    wb(A_WR, 1'b0);
    wb(8'hc4, 1'b0);
    op(CMD_START, 8'h00, 1'b0);
    wb(A_RD, 1'b0);
    rb(1'b1, 8'hc4 ^ 8'h5a);
    rb(1'b0, 8'hc0 ^ 8'h5a);
    op(CMD_STOP, 8'h00, 1'b0);
    check8("result reads", 8'h01, 8'(n_res));
    $display("test random_read done");
    sel_pins <= 2'h1;
    op(CMD_START, 8'h00, 1'b0);
    wb(A_WR, 1'b1);
    op(CMD_STOP, 8'h00, 1'b0);
    sel_pins <= SEL;
    op(CMD_START, 8'h00, 1'b0);
    wb(A_RD, 1'b0);
    rb(1'b0, 8'hc1 ^ 8'h5a);
    op(CMD_STOP, 8'h00, 1'b0);
    check8("result reads", 8'h02, 8'(n_res));
    $display("test current_read done");
    op(CMD_START, 8'h00, 1'b0);
    wb(A_WR, 1'b0);
    wb(8'he6, 1'b0);
    op(CMD_START, 8'h00, 1'b0);
    wb(A_RD, 1'b0);
    rb(1'b1, 8'h22);
    rb(1'b0, 8'h33);
    op(CMD_STOP, 8'h00, 1'b0);
    check8("counter", 8'he1, rd_addr);
    check8("read strobes", 8'h05, 8'(n_rd));
    $display("test setup_wrap done");
    print_verdict();
  end
endmodule // compass_i2c_slave_port_tb
`default_nettype wire
